// [design/pag_consts.svh]
// Constants for the port A pin block: register offsets, reset values, masks, bit positions.
// Assumes an 8-bit register port with byte offsets on an 8-bit address.
`ifndef PAG_CONSTS_SVH
`define PAG_CONSTS_SVH

`define PAG_ADDR_W 8
`define PAG_DATA_W 8

`define PAG_OFF_PIN 8'h00
`define PAG_OFF_LAT 8'h04
`define PAG_OFF_DIR 8'h08
`define PAG_OFF_ANA 8'h0c
`define PAG_OFF_CMP 8'h10
`define PAG_OFF_CVR 8'h14
`define PAG_OFF_CFG 8'h18

// Bit 4 has no pin behind it
`define PAG_IMPL_MASK 8'hef
// Pins that can be analog inputs: 0 to 3 and 5
`define PAG_ANA_MASK 8'h2f
// Comparator 1 inputs on pins 0 and 3, comparator 2 inputs on pins 1 and 2
`define PAG_CMP1_MASK 8'h09
`define PAG_CMP2_MASK 8'h06

`define PAG_LAT_RST 8'h00
`define PAG_DIR_RST 8'hef
`define PAG_ANA_RST 8'h00
`define PAG_CMP_RST 2'h0
`define PAG_CVR_RST 1'h0
`define PAG_CFG_RST 3'h0

`define PAG_BIT_CMP1 0
`define PAG_BIT_CMP2 1
`define PAG_BIT_REMAP0 0
`define PAG_BIT_REMAP1 1
`define PAG_BIT_PMA 2
`define PAG_PIN_COMPARATOR_REFERENCE_OUTPUT 2
`define PAG_PIN_PMA 1
`define PAG_PIN_CYCLE_CLOCK_OUTPUT 6
`define PAG_PIN_CLKI 7
`define PAG_DIV_W 2

`endif

// [design/pag_pkg.sv]
// Types shared by the port A pin block.
// Assumes the constants header is included by the modules that need numbers.
package pag_pkg;

    typedef enum logic [1:0] {
        PAG_OSC_INT = 2'h0,
        PAG_OSC_HS = 2'h1,
        PAG_OSC_RCEC = 2'h2,
        PAG_OSC_SPARE = 2'h3
    } pag_osc_type;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pag_pad_type;

    typedef struct packed {
        logic [1:0] remap_out;
        logic pma_out;
    } pag_periph_type;

endpackage

// [design/pag_pin_sync.sv]
// Two-stage synchroniser for the port pin inputs, one chain per bit.
// Assumes pad levels may change at any time relative to clk.
`timescale 1ns/1ps
module pag_pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_r[i] <= 1'b0;
                    sync_r[i] <= 1'b0;
                end else begin
                    meta_r[i] <= pin_in[i];
                    sync_r[i] <= meta_r[i];
                end
            end
        end
    endgenerate

    assign pin_sync = sync_r;
endmodule

// [design/pag_cycle_clock.sv]
// Divider that makes the instruction cycle clock, one quarter of the core clock rate.
// Assumes clk is the oscillator clock; the output is a registered square wave.
`timescale 1ns/1ps
`include "pag_consts.svh"
module pag_cycle_clock (
    input wire logic clk,
    input wire logic rst_n,
    output logic cycle_clk
);
    logic [`PAG_DIV_W-1:0] cnt_r;
    logic [`PAG_DIV_W-1:0] cnt_nxt;
    logic out_r;
    logic out_nxt;

    always_comb begin
        cnt_nxt = cnt_r + `PAG_DIV_W'(1);
        out_nxt = cnt_r[`PAG_DIV_W-1];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            out_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
        end
    end

    assign cycle_clk = out_r;
endmodule

// [design/pag_port_a.sv]
// Port A pin block: seven bidirectional pins with latch, direction and pin read paths,
// analog selection, comparator and reference overrides, remap and address sharing.
// Assumes a one-cycle register port on clk and pads resolved outside from out/oe.
//
// Functional notes
// (RULE1) Seven pins, each with direction, latch, read
// (RULE2) Oscillator mode can take two pins away
// (RULE3) Direction one puts driver in high impedance
// (RULE4) Direction zero drives the latch value out
// (RULE5) Pin register reads pins, writes latch
// (RULE6) Latch register separately addressed, reads latch
// (RULE7) Analog config picks analog for 0-3, 5
// (RULE8) Software turns comparators off for digital inputs
// (RULE9) After reset analog pins analog, read zero
// (RULE10) Direction still controls drivers in analog mode
// (RULE11) Software keeps analog pins set as inputs
// (RULE12) Analog pin reads zero on digital path
// (RULE13) Analog selection leaves output path untouched
// (RULE14) Reference output on pin 2 kills digital
// (RULE15) Pins 0,1 carry remap input and output
// (RULE16) Large package: pin 1 carries address bit 7
// (RULE17) RC/EC mode: pin 6 outputs cycle clock
// (RULE18) Bit 4 unimplemented, reads as zero
// (RULE19) Pin inputs synchronised before port reads
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "pag_consts.svh"
module pag_port_a
    import pag_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [`PAG_ADDR_W-1:0] reg_addr,
    input wire logic [`PAG_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`PAG_DATA_W-1:0] reg_rdata,
    // Oscillator mode from the configuration fuses
    input wire pag_osc_type osc_mode,
    // Pads
    input wire logic [7:0] pad_in,
    output pag_pad_type pad,
    // Peripherals sharing the pins
    input wire pag_periph_type periph,
    output logic [1:0] remap_in,
    output logic [7:0] analog_sel,
    output logic cmp_ref_out_en,
    output logic osc_owns_pins
);
    logic [7:0] lat_r;
    logic [7:0] lat_nxt;
    logic [7:0] dir_r;
    logic [7:0] dir_nxt;
    logic [7:0] ana_r;
    logic [7:0] ana_nxt;
    logic [1:0] cmp_r;
    logic [1:0] cmp_nxt;
    logic cvr_r;
    logic cvr_nxt;
    logic [2:0] cfg_r;
    logic [2:0] cfg_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    logic [7:0] pin_sync;
    logic cycle_clk;
    logic [7:0] osc_take;
    logic [7:0] cmp_take;
    logic [7:0] cvr_take;
    logic [7:0] dig_in_en;
    logic [7:0] pin_read;
    logic [7:0] drive_val;
    logic [7:0] drive_en;
    logic [7:0] out_nxt;
    logic [7:0] oe_nxt;
    logic [7:0] out_r;
    logic [7:0] oe_r;
    logic [1:0] remap_nxt;
    logic [1:0] remap_r;
    logic pma_on;
    // Named copy so single bits of the mask can be indexed
    localparam logic [7:0] IMPL_MASK = `PAG_IMPL_MASK;

    pag_pin_sync #(
        .WIDTH(8)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in(pad_in),
        .pin_sync(pin_sync)
    ); // [RULE19]

    pag_cycle_clock u_cyc (
        .clk(clk),
        .rst_n(rst_n),
        .cycle_clk(cycle_clk)
    );

    // Pins the oscillator claims in the current mode
    always_comb begin
        osc_take = 8'h00;
        unique case (osc_mode)
            PAG_OSC_HS: begin
                osc_take[`PAG_PIN_CYCLE_CLOCK_OUTPUT] = 1'b1; // [RULE2]
                osc_take[`PAG_PIN_CLKI] = 1'b1; // [RULE2]
            end
            PAG_OSC_RCEC: begin
                osc_take[`PAG_PIN_CLKI] = 1'b1; // [RULE2]
            end
            PAG_OSC_INT: begin
                osc_take = 8'h00;
            end
            default: begin
                osc_take = 8'h00;
            end
        endcase
    end

    // Sources that cut off the digital paths of a pin
    always_comb begin
        analog_sel = ~ana_r & `PAG_ANA_MASK; // [RULE7]
        cmp_take = 8'h00;
        if (cmp_r[`PAG_BIT_CMP1]) begin
            cmp_take = cmp_take | `PAG_CMP1_MASK;
        end
        if (cmp_r[`PAG_BIT_CMP2]) begin
            cmp_take = cmp_take | `PAG_CMP2_MASK;
        end
        cvr_take = 8'h00;
        cvr_take[`PAG_PIN_COMPARATOR_REFERENCE_OUTPUT] = cvr_r; // [RULE14]
        pma_on = LARGE_PKG && cfg_r[`PAG_BIT_PMA]; // [RULE16]
    end

    // A pin reads zero while analog, comparator, reference or oscillator owns it
    always_comb begin
        dig_in_en = `PAG_IMPL_MASK & ~osc_take & ~analog_sel & ~cmp_take & ~cvr_take; // [RULE12]
        pin_read = pin_sync & dig_in_en; // [RULE5] [RULE18]
    end

    // Output value per pin; latch unless a peripheral holds the pin
    always_comb begin
        drive_val = lat_r; // [RULE4] [RULE13]
        if (cfg_r[`PAG_BIT_REMAP0]) begin
            drive_val[0] = periph.remap_out[0]; // [RULE15]
        end
        if (pma_on) begin
            drive_val[`PAG_PIN_PMA] = periph.pma_out; // [RULE16]
        end else if (cfg_r[`PAG_BIT_REMAP1]) begin
            drive_val[1] = periph.remap_out[1]; // [RULE15]
        end
        if (osc_mode == PAG_OSC_RCEC) begin
            drive_val[`PAG_PIN_CYCLE_CLOCK_OUTPUT] = cycle_clk; // [RULE17]
        end
    end

    // Driver enable per pin, one bit each
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_pin
            always_comb begin
                // Analog selection deliberately absent here: direction, oscillator and reference govern
                drive_en[i] = IMPL_MASK[i] && !osc_take[i] && !cvr_take[i]
                    && !dir_r[i]; // [RULE3] [RULE10] [RULE14]
            end
        end
    endgenerate

    always_comb begin
        out_nxt = drive_val & `PAG_IMPL_MASK; // [RULE1]
        oe_nxt = drive_en;
        if (osc_mode == PAG_OSC_RCEC) begin
            oe_nxt[`PAG_PIN_CYCLE_CLOCK_OUTPUT] = 1'b1; // [RULE17]
        end
        // Remap input only follows the pin while the pin is an input
        remap_nxt[0] = dir_r[0] && pin_sync[0]; // [RULE15]
        remap_nxt[1] = dir_r[1] && pin_sync[1]; // [RULE15]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_r <= `PAG_LAT_RST;
            oe_r <= 8'h00;
            remap_r <= 2'h0;
        end else begin
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            remap_r <= remap_nxt;
        end
    end

    // Register writes
    always_comb begin
        lat_nxt = lat_r;
        dir_nxt = dir_r;
        ana_nxt = ana_r;
        cmp_nxt = cmp_r;
        cvr_nxt = cvr_r;
        cfg_nxt = cfg_r;
        if (reg_wr) begin
            unique case (reg_addr)
                `PAG_OFF_PIN: begin
                    lat_nxt = reg_wdata & `PAG_IMPL_MASK; // [RULE5] [RULE18]
                end
                `PAG_OFF_LAT: begin
                    lat_nxt = reg_wdata & `PAG_IMPL_MASK; // [RULE6] [RULE18]
                end
                `PAG_OFF_DIR: begin
                    dir_nxt = reg_wdata & `PAG_IMPL_MASK; // [RULE1] [RULE18]
                end
                `PAG_OFF_ANA: begin
                    ana_nxt = reg_wdata & `PAG_ANA_MASK; // [RULE7]
                end
                `PAG_OFF_CMP: begin
                    cmp_nxt = reg_wdata[1:0];
                end
                `PAG_OFF_CVR: begin
                    cvr_nxt = reg_wdata[0]; // [RULE14]
                end
                `PAG_OFF_CFG: begin
                    cfg_nxt = reg_wdata[2:0];
                end
                default: begin
                    lat_nxt = lat_r;
                end
            endcase
        end
    end

    // Register reads; data stand only in the cycle after the strobe
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `PAG_OFF_PIN: begin
                    rdata_nxt = pin_read; // [RULE5] [RULE9]
                end
                `PAG_OFF_LAT: begin
                    rdata_nxt = lat_r; // [RULE6]
                end
                `PAG_OFF_DIR: begin
                    rdata_nxt = dir_r; // [RULE18]
                end
                `PAG_OFF_ANA: begin
                    rdata_nxt = ana_r;
                end
                `PAG_OFF_CMP: begin
                    rdata_nxt = {6'h00, cmp_r};
                end
                `PAG_OFF_CVR: begin
                    rdata_nxt = {7'h00, cvr_r};
                end
                `PAG_OFF_CFG: begin
                    rdata_nxt = {5'h00, cfg_r};
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    // Analog config clears to all-analog so converter pins come up safe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lat_r <= `PAG_LAT_RST;
            dir_r <= `PAG_DIR_RST;
            ana_r <= `PAG_ANA_RST; // [RULE9]
            cmp_r <= `PAG_CMP_RST;
            cvr_r <= `PAG_CVR_RST;
            cfg_r <= `PAG_CFG_RST;
            rdata_r <= 8'h00;
        end else begin
            lat_r <= lat_nxt;
            dir_r <= dir_nxt;
            ana_r <= ana_nxt;
            cmp_r <= cmp_nxt;
            cvr_r <= cvr_nxt;
            cfg_r <= cfg_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign pad.out = out_r;
    assign pad.oe = oe_r;
    assign remap_in = remap_r;
    assign cmp_ref_out_en = cvr_r;
    assign osc_owns_pins = |osc_take;
endmodule

// [tb/pag_port_a_asserts.sv]
// Port-level assertions for the port A pin block.
// Assumes one clock domain; bound into every pag_port_a instance.
`timescale 1ns/1ps
`include "pag_consts.svh"
module pag_port_a_chk
    import pag_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`PAG_ADDR_W-1:0] reg_addr,
    input wire logic [`PAG_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`PAG_DATA_W-1:0] reg_rdata,
    input wire pag_osc_type osc_mode,
    input wire logic [7:0] pad_in,
    input wire pag_pad_type pad,
    input wire pag_periph_type periph,
    input wire logic [1:0] remap_in,
    input wire logic [7:0] analog_sel,
    input wire logic cmp_ref_out_en,
    input wire logic osc_owns_pins
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    chk_bit4_dead: assert property (!pad.oe[4] && !pad.out[4] && !reg_rdata[4])
        else $error("bit 4 active");
    chk_osc_owner: assert property (
        osc_owns_pins == (osc_mode inside {PAG_OSC_HS, PAG_OSC_RCEC}))
        else $error("oscillator ownership wrong");
    chk_hs_pins: assert property ((osc_mode == PAG_OSC_HS)[*2] |-> pad.oe[7:6] == 2'h0)
        else $error("oscillator pins driven");
    // Pin 6 must be a square wave of period four while the mode holds
    chk_cycle_clock_output_wave: assert property (
        (osc_mode == PAG_OSC_RCEC)[*6] |-> pad.oe[6] && pad.out[6] != $past(pad.out[6], 2))
        else $error("cycle clock output wrong");
    chk_ana_zero: assert property (
        reg_rd && reg_addr == `PAG_OFF_PIN |=> (reg_rdata & $past(analog_sel)) == 8'h00)
        else $error("analog pin read nonzero");
    chk_comparator_reference_output_off: assert property (
        cmp_ref_out_en && $past(cmp_ref_out_en) |-> !pad.oe[2])
        else $error("reference pin driven");
    chk_latch_out: assert property (
        reg_wr && reg_addr inside {`PAG_OFF_PIN, `PAG_OFF_LAT}
        |-> ##2 (pad.out & 8'h28) == ($past(reg_wdata, 2) & 8'h28))
        else $error("latch not on pad");
    chk_dir_drive: assert property (
        reg_wr && reg_addr == `PAG_OFF_DIR
        |-> ##2 (pad.oe & 8'h28) == (~$past(reg_wdata, 2) & 8'h28))
        else $error("direction not on enable");
    cov_pin_read: cover property (reg_rd && reg_addr == `PAG_OFF_PIN);
    cov_cycle_clock_output: cover property (osc_mode == PAG_OSC_RCEC && pad.oe[6]);
    cov_comparator_reference_output: cover property (cmp_ref_out_en);
endmodule
bind pag_port_a pag_port_a_chk #(.LARGE_PKG(LARGE_PKG)) chk_u (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .osc_mode(osc_mode), .pad_in(pad_in), .pad(pad), .periph(periph),
    .remap_in(remap_in), .analog_sel(analog_sel), .cmp_ref_out_en(cmp_ref_out_en),
    .osc_owns_pins(osc_owns_pins));

// [tb/tb.sv]
// Self-checking bench for the port A pin block over its register port.
// Assumes the default large package and pads seen as out/enable pairs.
`timescale 1ns/1ps
`include "pag_consts.svh"
module tb
    import pag_pkg::*;
;
    logic clk;
    logic rst_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, pad_in;
    logic reg_wr, reg_rd, osc_owns_pins, cmp_ref_out_en;
    logic [7:0] analog_sel;
    logic [1:0] remap_in;
    logic [3:0] s;
    pag_osc_type osc_mode;
    pag_pad_type pad;
    pag_periph_type periph;
    int num_errors, compares, cycles;
    pag_port_a dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_mode(osc_mode),
        .pad_in(pad_in), .pad(pad), .periph(periph), .remap_in(remap_in),
        .analog_sel(analog_sel), .cmp_ref_out_en(cmp_ref_out_en),
        .osc_owns_pins(osc_owns_pins));
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand one cycle only, so look mid-cycle after the strobe edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        osc_mode = PAG_OSC_INT;
        pad_in = 8'hff;
        periph = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(`PAG_OFF_LAT, 8'h00);
        rd(`PAG_OFF_DIR, 8'hef);
        rd(`PAG_OFF_PIN, 8'hc0);
        chk(pad.oe, 8'h00);
        chk(analog_sel, 8'h2f);
        wr(`PAG_OFF_PIN, 8'hff);
        rd(`PAG_OFF_LAT, 8'hef);
        rd(`PAG_OFF_PIN, 8'hc0);
        wr(8'h20, 8'hff);
        rd(8'h20, 8'h00);
        $display("test reset done");
        wr(`PAG_OFF_ANA, 8'h2f);
        rd(`PAG_OFF_PIN, 8'hef);
        chk(analog_sel, 8'h00);
        @(posedge clk);
        pad_in <= 8'ha5;
        rd(`PAG_OFF_PIN, 8'hef);
        rd(`PAG_OFF_PIN, 8'ha5);
        wr(`PAG_OFF_CMP, 8'h01);
        rd(`PAG_OFF_PIN, 8'ha4);
        wr(`PAG_OFF_CMP, 8'h02);
        rd(`PAG_OFF_PIN, 8'ha1);
        wr(`PAG_OFF_CMP, 8'h00);
        wr(`PAG_OFF_ANA, 8'h00);
        rd(`PAG_OFF_PIN, 8'h80);
        $display("test inputs done");
        wr(`PAG_OFF_DIR, 8'h00);
        wr(`PAG_OFF_LAT, 8'h2d);
        settle(2);
        chk(pad.oe, 8'hef);
        chk(pad.out, 8'h2d);
        wr(`PAG_OFF_CVR, 8'h01);
        wr(`PAG_OFF_ANA, 8'h2f);
        settle(2);
        chk(pad.oe, 8'heb);
        chk({7'h00, cmp_ref_out_en}, 8'h01);
        rd(`PAG_OFF_PIN, 8'ha1);
        wr(`PAG_OFF_CVR, 8'h00);
        $display("test outputs done");
        @(posedge clk);
        periph.remap_out <= 2'h2;
        wr(`PAG_OFF_CFG, 8'h03);
        settle(2);
        chk(pad.out, 8'h2e);
        @(posedge clk);
        periph <= '{remap_out: 2'h0, pma_out: 1'b1};
        wr(`PAG_OFF_CFG, 8'h07);
        settle(2);
        chk(pad.out, 8'h2e);
        wr(`PAG_OFF_CFG, 8'h04);
        settle(2);
        chk(pad.out, 8'h2f);
        wr(`PAG_OFF_CFG, 8'h00);
        @(posedge clk);
        pad_in <= 8'h03;
        wr(`PAG_OFF_DIR, 8'hff);
        settle(4);
        chk({6'h00, remap_in}, 8'h03);
        wr(`PAG_OFF_DIR, 8'h00);
        settle(2);
        chk({6'h00, remap_in}, 8'h00);
        $display("test shared done");
        @(posedge clk);
        osc_mode <= PAG_OSC_HS;
        settle(2);
        chk({7'h00, osc_owns_pins}, 8'h01);
        chk(pad.oe, 8'h2f);
        @(posedge clk);
        osc_mode <= PAG_OSC_RCEC;
        settle(3);
        chk(pad.oe, 8'h6f);
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            s[i] = pad.out[6];
        end
        chk({6'h00, s[0] ^ s[2], s[1] ^ s[3]}, 8'h03);
        @(posedge clk);
        osc_mode <= PAG_OSC_INT;
        settle(2);
        chk({7'h00, osc_owns_pins}, 8'h00);
        $display("test oscillator done");
        report_and_stop();
    end
endmodule
